// ===== hdl/eitc_consts.svh
// Constants of the external interrupt trigger configuration block.
`ifndef EITC_CONSTS_SVH
`define EITC_CONSTS_SVH

`define EITC_NPIN        24
`define EITC_PINS_PER_REG 8
`define EITC_FLD_W       3
`define EITC_FLT_FIXED   8

`define EITC_CTRL0_ADDR  32'h56000088
`define EITC_CTRL1_ADDR  32'h5600008C
`define EITC_CTRL2_ADDR  32'h56000090
`define EITC_STAT_ADDR   32'h560000C0
`define EITC_MASK_ADDR   32'h560000C4
`define EITC_LIVE_ADDR   32'h560000C8

`define EITC_CTRL_RESET  32'h00000000
`define EITC_CTRL0_WMASK 32'h77777777
`define EITC_CTRLN_WMASK 32'hFFFFFFFF

`define EITC_MODE_LOW    3'h0
`define EITC_MODE_HIGH   3'h1
`define EITC_EDGE_FALL   2'h1
`define EITC_EDGE_RISE   2'h2
`define EITC_EDGE_BOTH   2'h3

`define EITC_CLK_NS      10
`define EITC_FLT_NS      40
`define EITC_FLT_CYC     ((`EITC_FLT_NS + `EITC_CLK_NS - 1) / `EITC_CLK_NS)
`define EITC_CNT_W       3

`endif

// ===== hdl/eitc_pin_sense.sv
// Pin synchroniser, noise filter and trigger detection for all external interrupt pins.
`timescale 1ns/10ps
`default_nettype none
`include "eitc_consts.svh"
module eitc_pin_sense (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Pins
  input  wire eitc_pkg::eitc_pins_type pin,
  // Configuration and requests
  eitc_sense_if.sense                sif
);
  import eitc_pkg::*;

  eitc_sense_st_type st_q;
  eitc_sense_st_type st_d;

  always_comb begin
    st_d = st_q;
    st_d.sync1 = pin;
    st_d.sync2 = st_q.sync1;
    st_d.prev  = st_q.flt;
    for (int i = 0; i < `EITC_NPIN; i++) begin
      if (!sif.flt_en[i]) begin
        st_d.flt[i] = st_q.sync2[i];
        st_d.cnt[i] = '0;
      end else if (st_q.sync2[i] == st_q.flt[i]) begin
        st_d.cnt[i] = '0;
      end else if (st_q.cnt[i] == `EITC_CNT_W'(`EITC_FLT_CYC - 1)) begin
        // The new level has stood for the full filter time.
        st_d.flt[i] = st_q.sync2[i];
        st_d.cnt[i] = '0;
      end else begin
        st_d.cnt[i] = st_q.cnt[i] + `EITC_CNT_W'(1);
      end
      st_d.req[i] = eitc_sense_hit(sif.mode[i], st_q.flt[i], st_q.prev[i]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sif.req = st_q.req;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  for (genvar g = 0; g < `EITC_NPIN; g++) begin : g_chk
    a_low_level: assert property (
      sif.mode[g] == `EITC_MODE_LOW |=> st_q.req[g] == !$past(st_q.flt[g]))
      else $error("low level request does not follow pin");
    a_high_level: assert property (
      sif.mode[g] == `EITC_MODE_HIGH |=> st_q.req[g] == $past(st_q.flt[g]))
      else $error("high level request does not follow pin");
    a_fall_edge: assert property (
      sif.mode[g][2:1] == `EITC_EDGE_FALL && st_q.prev[g] && !st_q.flt[g] |=> st_q.req[g])
      else $error("falling edge not reported");
    a_rise_edge: assert property (
      sif.mode[g][2:1] == `EITC_EDGE_RISE && !st_q.prev[g] && st_q.flt[g] |=> st_q.req[g])
      else $error("rising edge not reported");
    a_both_edge: assert property (
      sif.mode[g][2:1] == `EITC_EDGE_BOTH && (st_q.prev[g] ^ st_q.flt[g]) |=> st_q.req[g])
      else $error("edge not reported in both edge mode");
    a_edge_single: assert property (
      st_q.req[g] && eitc_is_edge(sif.mode[g]) && sif.flt_en[g] && $stable(sif.mode[g])
        && $stable(sif.flt_en[g]) |=> !st_q.req[g])
      else $error("edge request longer than one cycle");
    a_level_filter: assert property (
      $changed(st_q.flt[g]) && $past(sif.flt_en[g]) |->
        $past(st_q.sync2[g], 1) == st_q.flt[g] && $past(st_q.sync2[g], 2) == st_q.flt[g]
        && $past(st_q.sync2[g], 3) == st_q.flt[g] && $past(st_q.sync2[g], 4) == st_q.flt[g])
      else $error("filtered level accepted before 40 ns");
  end

endmodule
`default_nettype wire

// ===== hdl/eitc_pkg.sv
// Types and sensing decode shared by the external interrupt trigger block.
`include "eitc_consts.svh"
package eitc_pkg;

  typedef logic [`EITC_NPIN-1:0] eitc_pins_type;
  typedef logic [`EITC_FLD_W-1:0] eitc_mode_type;

  typedef enum logic [2:0] {
    EITC_SEL_NONE  = 3'h0,
    EITC_SEL_CTRL0 = 3'h1,
    EITC_SEL_CTRL1 = 3'h3,
    EITC_SEL_CTRL2 = 3'h2,
    EITC_SEL_STAT  = 3'h6,
    EITC_SEL_MASK  = 3'h7,
    EITC_SEL_LIVE  = 3'h5
  } eitc_sel_type;

  typedef struct packed {
    logic [31:0]   ctrl0;
    logic [31:0]   ctrl1;
    logic [31:0]   ctrl2;
    eitc_pins_type stat;
    eitc_pins_type mask;
    eitc_pins_type req;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
  } eitc_top_st_type;

  typedef struct packed {
    eitc_pins_type                             sync1;
    eitc_pins_type                             sync2;
    eitc_pins_type                             flt;
    eitc_pins_type                             prev;
    eitc_pins_type                             req;
    logic [`EITC_NPIN-1:0][`EITC_CNT_W-1:0]    cnt;
  } eitc_sense_st_type;

  // True when the filtered pin state qualifies under the given sensing code.
  function automatic logic eitc_sense_hit(eitc_mode_type mode, logic cur, logic prev);
    logic hit;
    hit = 1'b0;
    if (mode == `EITC_MODE_LOW) begin
      hit = !cur;
    end else if (mode == `EITC_MODE_HIGH) begin
      hit = cur;
    end else if (mode[2:1] == `EITC_EDGE_FALL) begin
      hit = prev && !cur;
    end else if (mode[2:1] == `EITC_EDGE_RISE) begin
      hit = !prev && cur;
    end else begin
      hit = prev ^ cur;
    end
    return hit;
  endfunction

  function automatic logic eitc_is_edge(eitc_mode_type mode);
    return mode[2] | mode[1];
  endfunction

endpackage

// ===== hdl/eitc_sense_if.sv
// Interface carrying pin configuration to the sensing logic and requests back.
`timescale 1ns/10ps
`default_nettype none
`include "eitc_consts.svh"
interface eitc_sense_if;
  // Nets, since each pin's field is driven by its own continuous assignment.
  wire logic [`EITC_NPIN-1:0][`EITC_FLD_W-1:0] mode;
  wire logic [`EITC_NPIN-1:0]                  flt_en;
  wire logic [`EITC_NPIN-1:0]                  req;
  modport ctl   (output mode, output flt_en, input req);
  modport sense (input mode, input flt_en, output req);
endinterface
`default_nettype wire

// ===== hdl/eitc_top.sv
// External interrupt trigger configuration: APB registers, sensing and interrupt status.
`timescale 1ns/10ps
`default_nettype none
`include "eitc_consts.svh"
module eitc_top (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  // APB slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [31:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output var  logic [31:0]             PRDATA,
  output var  logic                    PREADY,
  output var  logic                    PSLVERR,
  // External interrupt pins
  input  wire eitc_pkg::eitc_pins_type EXT_IRQ_PIN,
  // Requests and interrupt
  output var  eitc_pkg::eitc_pins_type EXT_IRQ_REQ,
  output var  logic                    IRQ
);
  import eitc_pkg::*;

  eitc_top_st_type st_q;
  eitc_top_st_type st_d;

  eitc_sense_if sif ();

  // Address decode, used by both the read and the write path.
  function automatic eitc_sel_type eitc_decode(logic [31:0] addr);
    eitc_sel_type sel;
    sel = EITC_SEL_NONE;
    if (addr == `EITC_CTRL0_ADDR) begin
      sel = EITC_SEL_CTRL0;
    end else if (addr == `EITC_CTRL1_ADDR) begin
      sel = EITC_SEL_CTRL1;
    end else if (addr == `EITC_CTRL2_ADDR) begin
      sel = EITC_SEL_CTRL2;
    end else if (addr == `EITC_STAT_ADDR) begin
      sel = EITC_SEL_STAT;
    end else if (addr == `EITC_MASK_ADDR) begin
      sel = EITC_SEL_MASK;
    end else if (addr == `EITC_LIVE_ADDR) begin
      sel = EITC_SEL_LIVE;
    end
    return sel;
  endfunction

  // Read multiplexer; status, mask and live bits above the pin count read as zero.
  function automatic logic [31:0] eitc_read(eitc_sel_type sel, eitc_top_st_type s);
    logic [31:0] d;
    d = 32'h00000000;
    unique case (sel)
      EITC_SEL_CTRL0: begin
        d = s.ctrl0;
      end
      EITC_SEL_CTRL1: begin
        d = s.ctrl1;
      end
      EITC_SEL_CTRL2: begin
        d = s.ctrl2;
      end
      EITC_SEL_STAT: begin
        d = 32'(s.stat);
      end
      EITC_SEL_MASK: begin
        d = 32'(s.mask);
      end
      EITC_SEL_LIVE: begin
        d = 32'(s.req);
      end
      default: begin
        d = 32'h00000000;
      end
    endcase
    return d;
  endfunction

  logic         acc_first;
  logic         acc_done;
  logic         wr_done;
  eitc_sel_type sel;

  assign acc_first = PSEL && PENABLE && !st_q.pready;
  assign acc_done  = PSEL && PENABLE && st_q.pready;
  assign wr_done   = acc_done && PWRITE;
  assign sel       = eitc_decode(PADDR);

  always_comb begin
    st_d = st_q;

    // One wait state: data and pready rise together in the second access cycle.
    st_d.pready  = acc_first;
    st_d.pslverr = acc_first && (sel == EITC_SEL_NONE);
    st_d.prdata  = 32'h00000000;
    if (acc_first && !PWRITE) begin
      st_d.prdata = eitc_read(sel, st_q);
    end

    // A write takes effect only at the edge where pready is sampled high.
    if (wr_done) begin
      unique case (sel)
        EITC_SEL_CTRL0: begin
          // Pins 0..7 have no filter enable, so those bits stay zero.
          st_d.ctrl0 = PWDATA & `EITC_CTRL0_WMASK;
        end
        EITC_SEL_CTRL1: begin
          st_d.ctrl1 = PWDATA & `EITC_CTRLN_WMASK;
        end
        EITC_SEL_CTRL2: begin
          st_d.ctrl2 = PWDATA & `EITC_CTRLN_WMASK;
        end
        EITC_SEL_MASK: begin
          st_d.mask = PWDATA[`EITC_NPIN-1:0];
        end
        default: begin
          st_d.mask = st_q.mask;
        end
      endcase
    end

    // Write one to clear; a request in the same cycle keeps its bit set.
    st_d.stat = st_q.stat;
    if (wr_done && sel == EITC_SEL_STAT) begin
      st_d.stat = st_q.stat & ~PWDATA[`EITC_NPIN-1:0];
    end
    st_d.stat = st_d.stat | sif.req;

    st_d.req = sif.req;
    st_d.irq = |(st_d.stat & st_d.mask);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q       <= '0;
      st_q.ctrl0 <= `EITC_CTRL_RESET;
      st_q.ctrl1 <= `EITC_CTRL_RESET;
      st_q.ctrl2 <= `EITC_CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Configuration fan-out: pin k takes nibble k mod 8 of register k div 8.
  for (genvar k = 0; k < `EITC_NPIN; k++) begin : g_cfg
    localparam int REG = k / `EITC_PINS_PER_REG;
    localparam int LSB = 4 * (k % `EITC_PINS_PER_REG);
    if (REG == 0) begin : g_r0
      assign sif.mode[k] = st_q.ctrl0[LSB +: `EITC_FLD_W];
    end else if (REG == 1) begin : g_r1
      assign sif.mode[k] = st_q.ctrl1[LSB +: `EITC_FLD_W];
    end else begin : g_r2
      assign sif.mode[k] = st_q.ctrl2[LSB +: `EITC_FLD_W];
    end
    if (k < `EITC_FLT_FIXED) begin : g_ff
      // These pins have no enable bit and keep the filter permanently on.
      assign sif.flt_en[k] = 1'b1;
    end else if (REG == 1) begin : g_f1
      assign sif.flt_en[k] = st_q.ctrl1[LSB + `EITC_FLD_W];
    end else begin : g_f2
      assign sif.flt_en[k] = st_q.ctrl2[LSB + `EITC_FLD_W];
    end
  end

  eitc_pin_sense u_sense (
    .clk   (CLK),
    .rst_b (RST_B),
    .pin   (EXT_IRQ_PIN),
    .sif   (sif.sense)
  );

  assign PRDATA      = st_q.prdata;
  assign PREADY      = st_q.pready;
  assign PSLVERR     = st_q.pslverr;
  assign EXT_IRQ_REQ = st_q.req;
  assign IRQ         = st_q.irq;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_ctrl0_write: assert property (
    wr_done && PADDR == `EITC_CTRL0_ADDR
      |=> st_q.ctrl0 == ($past(PWDATA) & `EITC_CTRL0_WMASK))
    else $error("first control register write lost");

  a_ctrl1_write: assert property (
    wr_done && PADDR == `EITC_CTRL1_ADDR
      |=> st_q.ctrl1 == $past(PWDATA) ##0 sif.flt_en[8] == st_q.ctrl1[3])
    else $error("second control register or filter enable wrong");

  a_ctrl2_write: assert property (
    wr_done && PADDR == `EITC_CTRL2_ADDR
      |=> st_q.ctrl2 == $past(PWDATA) ##0 sif.mode[23] == st_q.ctrl2[30:28])
    else $error("third control register write lost");

  a_mode_map: assert property (
    sif.mode[15] == st_q.ctrl1[30:28] && sif.mode[8] == st_q.ctrl1[2:0]
      && sif.mode[7] == st_q.ctrl0[30:28])
    else $error("sensing field mapped to wrong pin");

  a_reset_zero: assert property (
    $rose(RST_B) |-> st_q.ctrl0 == '0 && st_q.ctrl1 == '0 && st_q.ctrl2 == '0)
    else $error("control registers not zero after reset");

  a_apb_wait: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("APB answer not in second access cycle");

  a_sticky_set: assert property (
    sif.req != '0 |=> (st_q.stat & $past(sif.req)) == $past(sif.req))
    else $error("request did not set its status bit");

  a_irq_level: assert property (
    ##1 IRQ == |($past(st_d.stat) & $past(st_d.mask)))
    else $error("interrupt output disagrees with status and mask");

  // Register bus answer checks.
  a_rdata_idle: assert property (
    !PREADY |-> PRDATA == 32'h00000000)
    else $error("read data not zero outside the answer cycle");

  a_err_unmapped: assert property (
    acc_first && sel == EITC_SEL_NONE |=> PREADY && PSLVERR)
    else $error("unmapped access without error");

  a_err_mapped: assert property (
    acc_first && sel != EITC_SEL_NONE |=> PREADY && !PSLVERR)
    else $error("mapped access answered with error");

  a_ready_pulse: assert property (
    PREADY |=> !PREADY)
    else $error("ready stood longer than one cycle");

  a_read_ctrl0: assert property (
    acc_first && !PWRITE && sel == EITC_SEL_CTRL0 |=> PRDATA == $past(st_q.ctrl0))
    else $error("first control register read wrong");

  a_read_ctrl1: assert property (
    acc_first && !PWRITE && sel == EITC_SEL_CTRL1 |=> PRDATA == $past(st_q.ctrl1))
    else $error("second control register read wrong");

  a_read_ctrl2: assert property (
    acc_first && !PWRITE && sel == EITC_SEL_CTRL2 |=> PRDATA == $past(st_q.ctrl2))
    else $error("third control register read wrong");

  a_read_stat: assert property (
    acc_first && !PWRITE && sel == EITC_SEL_STAT |=> PRDATA == 32'($past(st_q.stat)))
    else $error("status read wrong");

  a_read_mask: assert property (
    acc_first && !PWRITE && sel == EITC_SEL_MASK |=> PRDATA == 32'($past(st_q.mask)))
    else $error("mask read wrong");

  a_read_live: assert property (
    acc_first && !PWRITE && sel == EITC_SEL_LIVE |=> PRDATA == 32'($past(st_q.req)))
    else $error("live request read wrong");

  // Control and mask register contents only move on a completed write.
  a_no_wr_read: assert property (
    acc_done && !PWRITE |=> $stable(st_q.ctrl0) && $stable(st_q.ctrl1) && $stable(st_q.ctrl2)
      && $stable(st_q.mask))
    else $error("read changed a register");

  a_live_ro: assert property (
    wr_done && sel == EITC_SEL_LIVE |=> $stable(st_q.ctrl0) && $stable(st_q.ctrl1)
      && $stable(st_q.ctrl2) && $stable(st_q.mask))
    else $error("write to live register changed state");

  a_mask_write: assert property (
    wr_done && sel == EITC_SEL_MASK |=> st_q.mask == $past(PWDATA[`EITC_NPIN-1:0]))
    else $error("mask write lost");

  a_ctrl0_reserved: assert property (
    (st_q.ctrl0 & ~`EITC_CTRL0_WMASK) == 32'h00000000)
    else $error("reserved bit of first control register set");

  // Status is sticky: only a write of one clears a bit.
  a_stat_clear: assert property (
    wr_done && sel == EITC_SEL_STAT && sif.req == '0
      |=> (st_q.stat & $past(PWDATA[`EITC_NPIN-1:0])) == '0)
    else $error("status bit not cleared by write of one");

  a_stat_hold: assert property (
    !(wr_done && sel == EITC_SEL_STAT) |=> (st_q.stat & $past(st_q.stat)) == $past(st_q.stat))
    else $error("status bit lost without a clear");

  a_req_out: assert property (
    1'b1 |=> EXT_IRQ_REQ == $past(sif.req))
    else $error("request output does not follow sensing");

  // Configuration fan-out checks.
  a_flt_fixed: assert property (
    sif.flt_en[`EITC_FLT_FIXED-1:0] == '1)
    else $error("fixed filter pins not filtered");

  a_flt_map: assert property (
    sif.flt_en[23] == st_q.ctrl2[31] && sif.flt_en[16] == st_q.ctrl2[3]
      && sif.flt_en[15] == st_q.ctrl1[31])
    else $error("filter enable mapped to wrong pin");

  a_mode_map2: assert property (
    sif.mode[16] == st_q.ctrl2[2:0] && sif.mode[0] == st_q.ctrl0[2:0])
    else $error("low sensing field mapped to wrong pin");

endmodule
`default_nettype wire

// ===== testbench/eitc_pin_src.sv
// Behavioural model of the external sources that drive the interrupt pins.
`timescale 1ns/10ps
`default_nettype none
module eitc_pin_src (
  // Clock
  input  wire logic                    clk,
  // Pins
  output var  eitc_pkg::eitc_pins_type pins
);
  import eitc_pkg::*;
  // Pins idle high, as with pull-ups, so that low-level sensing stays quiet.
  initial pins = '1;
  // Changes land just after an edge, so the synchroniser never sees a race.
  task automatic drive(input int idx, input logic v);
    pins[idx] <= v;
  endtask
  // Inverts a pin for a number of cycles and then restores it.
  task automatic glitch(input int idx, input int ncyc);
    pins[idx] <= ~pins[idx];
    repeat (ncyc) @(posedge clk);
    pins[idx] <= ~pins[idx];
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_ext_interrupt_trigger_config.sv
// Self-checking testbench of the external interrupt trigger configuration block.
`timescale 1ns/10ps
`default_nettype none
`include "eitc_consts.svh"
module test_ext_interrupt_trigger_config;
  import eitc_pkg::*;
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [31:0]   paddr = 32'h0;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          irq;
  eitc_pins_type pin;
  eitc_pins_type req;
  int            num_errors = 0;
  int            n_checks = 0;

  always #5 clk = ~clk;

  eitc_top dut_u (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_IRQ_PIN(pin), .EXT_IRQ_REQ(req), .IRQ(irq)
  );
  eitc_pin_src src_u (.clk(clk), .pins(pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished, errors so far %0d", name, num_errors);
  endtask

  // The request is held until ready; an idle cycle follows so strobes never toggle twice in one step.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    if (n >= 16) chk(32'h0, 32'h1, "no ready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0, "write error");
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, 32'h0, "read error");
    chk(r, exp, what);
  endtask

  task automatic count(input int idx, input int ncyc, output int hi);
    hi = 0;
    repeat (ncyc) begin
      @(posedge clk);
      if (req[idx] === 1'b1) hi++;
    end
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd(`EITC_CTRL0_ADDR, `EITC_CTRL_RESET, "ctrl0 reset");
    rd(`EITC_CTRL1_ADDR, `EITC_CTRL_RESET, "ctrl1 reset");
    rd(`EITC_CTRL2_ADDR, `EITC_CTRL_RESET, "ctrl2 reset");
    rd(`EITC_MASK_ADDR, 32'h0, "mask reset");
    apb(1'b0, 32'h56000094, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    done("reset");
  endtask

  task automatic t_layout();
    wr(`EITC_CTRL0_ADDR, 32'hFFFFFFFF);
    rd(`EITC_CTRL0_ADDR, `EITC_CTRL0_WMASK, "ctrl0 fields");
    wr(`EITC_CTRL1_ADDR, 32'hFFFFFFFF);
    rd(`EITC_CTRL1_ADDR, 32'hFFFFFFFF, "ctrl1 fields");
    wr(`EITC_CTRL2_ADDR, 32'hA5A5A5A5);
    rd(`EITC_CTRL2_ADDR, 32'hA5A5A5A5, "ctrl2 fields");
    // The top field of each register selects high level; idle-high pins must then request.
    for (int k = 0; k < 3; k++) begin
      wr(`EITC_CTRL0_ADDR + 4 * k, 32'h90000000);
      repeat (12) @(posedge clk);
      chk({31'h0, req[8 * k + 7]}, 32'h1, "top field pin");
      chk({31'h0, req[8 * k + 6]}, 32'h0, "neighbour pin");
      wr(`EITC_CTRL0_ADDR + 4 * k, 32'h0);
    end
    done("layout");
  endtask

  task automatic t_level();
    int h;
    wr(`EITC_CTRL1_ADDR, 32'h10);
    src_u.drive(9, 1'b0);
    repeat (8) @(posedge clk);
    chk({31'h0, req[9]}, 32'h0, "high level idle");
    src_u.drive(9, 1'b1);
    repeat (8) @(posedge clk);
    count(9, 10, h);
    chk(h, 10, "high level held");
    wr(`EITC_CTRL1_ADDR, 32'h0);
    src_u.drive(9, 1'b0);
    repeat (8) @(posedge clk);
    count(9, 10, h);
    chk(h, 10, "low level held");
    src_u.drive(9, 1'b1);
    repeat (8) @(posedge clk);
    chk({31'h0, req[9]}, 32'h0, "low level released");
    done("level");
  endtask

  task automatic t_edges();
    int          h1;
    int          h2;
    logic [2:0]  c;
    for (int i = 2; i < 8; i++) begin
      c = i[2:0];
      wr(`EITC_CTRL2_ADDR, {29'h0, c});
      src_u.drive(16, 1'b0);
      count(16, 10, h1);
      src_u.drive(16, 1'b1);
      count(16, 10, h2);
      chk(h1, {31'h0, c[1]}, "falling pulses");
      chk(h2, {31'h0, c[2]}, "rising pulses");
    end
    wr(`EITC_CTRL2_ADDR, 32'h0);
    done("edges");
  endtask

  task automatic t_filter();
    int h;
    wr(`EITC_CTRL1_ADDR, 32'h8);
    src_u.glitch(8, 2);
    count(8, 12, h);
    chk(h, 0, "filtered glitch");
    wr(`EITC_CTRL1_ADDR, 32'h0);
    src_u.glitch(8, 2);
    count(8, 12, h);
    chk(h, 2, "bypassed glitch");
    wr(`EITC_CTRL1_ADDR, 32'h8);
    src_u.glitch(8, 6);
    count(8, 12, h);
    chk({31'h0, h != 0}, 32'h1, "long low accepted");
    src_u.glitch(0, 2);
    count(0, 12, h);
    chk(h, 0, "pin 0 glitch");
    wr(`EITC_CTRL1_ADDR, 32'h0);
    done("filter");
  endtask

  task automatic t_irq();
    wr(`EITC_STAT_ADDR, 32'h00FFFFFF);
    rd(`EITC_STAT_ADDR, 32'h0, "status cleared");
    wr(`EITC_CTRL2_ADDR, 32'h2);
    src_u.glitch(16, 2);
    repeat (12) @(posedge clk);
    rd(`EITC_STAT_ADDR, 32'h00010000, "edge status");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(`EITC_MASK_ADDR, 32'h00010000);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(`EITC_STAT_ADDR, 32'h00010000);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    rd(`EITC_STAT_ADDR, 32'h0, "status after clear");
    wr(`EITC_MASK_ADDR, 32'h0);
    wr(`EITC_CTRL2_ADDR, 32'h0);
    done("irq");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_layout();
    t_level();
    t_edges();
    t_filter();
    t_irq();
    tally_and_finish();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
